// >>> inc/bpr_regs.vh
`ifndef BPR_REGS_VH
`define BPR_REGS_VH
// ****************************************
// block geometry and sample widths
// ****************************************
`define BPR_BLK_PIX 64
`define BPR_COEF_W 12
`define BPR_MID_W 18
`define BPR_RES_W 9
`define BPR_PIX_W 8
// ****************************************
// fixed-point scaling of the two passes
// ****************************************
`define BPR_ROW_SHIFT 10
`define BPR_COL_SHIFT 16
// ****************************************
// clip limits
// ****************************************
`define BPR_RES_MIN (-256)
`define BPR_RES_MAX 255
`define BPR_PIX_MIN 0
`define BPR_PIX_MAX 255
`endif

// >>> core/bpr_idct_1d.v
`timescale 1ns/1ps
`include "bpr_regs.vh"
// ****************************************
// one output of an 8-point inverse transform
// ****************************************
module bpr_idct_1d #(
	parameter IW = 12,
	parameter OW = 18,
	parameter SH = 10
) (
	// eight transform-domain samples, index 0 in the low bits
	input wire [8*IW-1:0] vecIn,
	// spatial position of the wanted output
	input wire [2:0] pos,
	// rounded output
	output wire signed [OW-1:0] sumOut
);
	localparam AW = IW + 17;
	localparam PW = IW + 14;

	// half cosine weights scaled by 8192, dc weight divided by sqrt 2
	function signed [13:0] cosTerm;
		input [2:0] x;
		input [2:0] u;
		reg [7:0] kw;
		reg [4:0] k;
		reg [4:0] m;
		reg neg;
		reg [12:0] mag;
		begin
			kw = ({5'h00, x} * 8'h02 + 8'h01) * {5'h00, u};
			k = kw[4:0]; // angle index modulo a full turn
			neg = (k > 5'h08) && (k < 5'h18);
			if (k <= 5'h08) begin
				m = k;
			end else if (k <= 5'h10) begin
				m = 5'h10 - k;
			end else if (k <= 5'h18) begin
				m = k - 5'h10;
			end else begin
				m = 5'h00 - k;
			end
			case (m)
				5'h00: mag = 13'h1000;
				5'h01: mag = 13'h0fb1;
				5'h02: mag = 13'h0ec8;
				5'h03: mag = 13'h0d4e;
				5'h04: mag = 13'h0b50;
				5'h05: mag = 13'h08e4;
				5'h06: mag = 13'h061f;
				5'h07: mag = 13'h031f;
				default: mag = 13'h0000;
			endcase
			if (u == 3'h0) begin
				mag = 13'h0b50;
			end
			cosTerm = neg ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
		end
	endfunction

	wire [8*PW-1:0] prodFlat;
	reg signed [AW-1:0] acc;
	reg signed [AW-1:0] shifted;
	integer i;

	// eight weighted samples
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : gen_mul
			localparam [2:0] GU = g;
			assign prodFlat[g*PW +: PW] = $signed(vecIn[g*IW +: IW]) * cosTerm(pos, GU);
		end
	endgenerate

	// sum, round to nearest, scale down; zero in gives zero out
	always @* begin
		acc = {AW{1'b0}};
		for (i = 0; i < 8; i = i + 1) begin
			acc = acc + {{3{prodFlat[i*PW+PW-1]}}, prodFlat[i*PW +: PW]};
		end
		acc = acc + ({{(AW-1){1'b0}}, 1'b1} <<< (SH - 1));
		shifted = acc >>> SH;
	end

	assign sumOut = shifted[OW-1:0];
endmodule // bpr_idct_1d

// >>> core/bpr_recon.v
`timescale 1ns/1ps
`include "bpr_regs.vh"
module bpr_recon (
	// clock and reset
	input wire sys_clk,
	input wire rstn,
	// coefficient stream, row-major, 64 per block
	input wire coefValid,
	output wire coefReady,
	input wire [`BPR_COEF_W-1:0] coefData,
	input wire blkIntra,
	// prediction stream, row-major, inter blocks only
	input wire predValid,
	output wire predReady,
	input wire [`BPR_PIX_W-1:0] predData,
	// reconstructed pixel stream
	output wire pixValid,
	input wire pixReady,
	output wire [`BPR_PIX_W-1:0] pixData
);
	localparam ST_LOAD = 2'h0;
	localparam ST_ROW = 2'h1;
	localparam ST_COL = 2'h2;
	localparam ST_OUT = 2'h3;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [5:0] idx_reg;
	reg intra_reg;
	reg pixValid_reg;
	reg [`BPR_PIX_W-1:0] pixData_reg;
	reg [`BPR_COEF_W-1:0] coefMem [0:63];
	reg [`BPR_MID_W-1:0] midMem [0:63];
	reg [`BPR_RES_W-1:0] resMem [0:63];

	// ****************************************
	// clip helpers
	// ****************************************
	function [`BPR_RES_W-1:0] clipRes;
		input signed [`BPR_MID_W-1:0] v;
		begin
			if (v < `BPR_RES_MIN) begin
				clipRes = 9'h100;
			end else if (v > `BPR_RES_MAX) begin
				clipRes = 9'h0ff;
			end else begin
				clipRes = v[`BPR_RES_W-1:0];
			end
		end
	endfunction

	function [`BPR_PIX_W-1:0] clipPix;
		input signed [`BPR_RES_W+1:0] v;
		begin
			if (v < `BPR_PIX_MIN) begin
				clipPix = 8'h00;
			end else if (v > `BPR_PIX_MAX) begin
				clipPix = 8'hff;
			end else begin
				clipPix = v[`BPR_PIX_W-1:0];
			end
		end
	endfunction

	// last position of a 64-entry pass
	function isLast;
		input [5:0] n;
		begin
			isLast = (n == 6'h3f);
		end
	endfunction

	// ****************************************
	// transform datapath
	// ****************************************
	wire [8*`BPR_COEF_W-1:0] rowVec;
	wire [8*`BPR_MID_W-1:0] colVec;
	wire signed [`BPR_MID_W-1:0] rowOut;
	wire signed [`BPR_MID_W-1:0] colOut;
	wire [2:0] hiIdx = idx_reg[5:3];
	wire [2:0] loIdx = idx_reg[2:0];

	// row pass reads row hiIdx, column pass reads column hiIdx
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : gen_vec
			localparam [2:0] GI = g;
			assign rowVec[g*`BPR_COEF_W +: `BPR_COEF_W] = coefMem[{hiIdx, GI}];
			assign colVec[g*`BPR_MID_W +: `BPR_MID_W] = midMem[{GI, hiIdx}];
		end
	endgenerate

	bpr_idct_1d #(
		.IW(`BPR_COEF_W),
		.OW(`BPR_MID_W),
		.SH(`BPR_ROW_SHIFT)
	) u_row (
		.vecIn(rowVec),
		.pos(loIdx),
		.sumOut(rowOut)
	);

	bpr_idct_1d #(
		.IW(`BPR_MID_W),
		.OW(`BPR_MID_W),
		.SH(`BPR_COL_SHIFT)
	) u_col (
		.vecIn(colVec),
		.pos(loIdx),
		.sumOut(colOut)
	);

	// ****************************************
	// output stage
	// ****************************************
	wire outSlot = !pixValid_reg || pixReady;
	// coefficient taken, first of a block, transform step
	wire loadFire = (state_reg == ST_LOAD) && coefValid;
	wire firstBeat = loadFire && (idx_reg == 6'h00);
	wire passStep = (state_reg == ST_ROW) || (state_reg == ST_COL);
	wire outFire = (state_reg == ST_OUT) && outSlot && (intra_reg || predValid);
	wire signed [`BPR_RES_W+1:0] resExt = {{2{resMem[idx_reg][`BPR_RES_W-1]}}, resMem[idx_reg]};
	wire signed [`BPR_RES_W+1:0] predExt = {3'h0, predData};
	wire signed [`BPR_RES_W+1:0] sumPix = intra_reg ? resExt : resExt + predExt;

	assign coefReady = (state_reg == ST_LOAD);
	assign predReady = (state_reg == ST_OUT) && !intra_reg && outSlot;
	assign pixValid = pixValid_reg;
	assign pixData = pixData_reg;

	// ****************************************
	// sequencing
	// ****************************************
	// next state from the pass counter
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_LOAD: begin
				if (coefValid && isLast(idx_reg)) begin
					state_next = ST_ROW;
				end
			end
			ST_ROW: begin
				if (isLast(idx_reg)) begin
					state_next = ST_COL;
				end
			end
			ST_COL: begin
				if (isLast(idx_reg)) begin
					state_next = ST_OUT;
				end
			end
			default: begin
				if (outFire && isLast(idx_reg)) begin
					state_next = ST_LOAD;
				end
			end
		endcase
	end

	// state, counter, block mode and output register
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_LOAD;
			idx_reg <= 6'h00;
			intra_reg <= 1'b0;
			pixValid_reg <= 1'b0;
			pixData_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (loadFire || passStep || outFire) begin
				idx_reg <= idx_reg + 6'h01;
			end
			if (firstBeat) begin
				intra_reg <= blkIntra; // mode held for the whole block
			end
			if (outFire) begin
				pixValid_reg <= 1'b1;
				pixData_reg <= clipPix(sumPix);
			end else if (pixReady) begin
				pixValid_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// block storage, no reset needed
	// ****************************************
	// coefficients in arrival order
	always @(posedge sys_clk) begin
		if (loadFire) begin
			coefMem[idx_reg] <= coefData;
		end
	end

	// row pass results, three fraction bits
	always @(posedge sys_clk) begin
		if (state_reg == ST_ROW) begin
			midMem[{hiIdx, loIdx}] <= rowOut;
		end
	end

	// clipped residuals, stored row-major
	always @(posedge sys_clk) begin
		if (state_reg == ST_COL) begin
			resMem[{loIdx, hiIdx}] <= clipRes(colOut);
		end
	end
endmodule // bpr_recon

// >>> sim/bpr_recon_sva.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module bpr_recon_sva (
	// clock, reset
	input wire sys_clk,
	input wire rstn,
	// streams
	input wire coefValid,
	input wire coefReady,
	input wire [11:0] coefData,
	input wire blkIntra,
	input wire predValid,
	input wire predReady,
	input wire [7:0] predData,
	input wire pixValid,
	input wire pixReady,
	input wire [7:0] pixData
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic [5:0] nLoad_reg;
	// coefficients taken, modulo one block
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			nLoad_reg <= 6'h00;
		else if (coefValid && coefReady)
			nLoad_reg <= nLoad_reg + 6'h01;
	end
	sequence sPop; predValid && predReady; endsequence
	sequence sStall; pixValid && !pixReady; endsequence
	a_pix_hold: assert property (sStall |=> pixValid && $stable(pixData))
		else $error("held pixel changed");
	a_pix_follow: assert property (sPop |=> pixValid)
		else $error("no pixel after pop");
	a_pop_slot: assert property (sPop |-> !pixValid || pixReady)
		else $error("pop with full slot");
	a_pop_stall: assert property (sStall |-> !predReady)
		else $error("ready while stalled");
	a_pop_load: assert property (coefReady |-> !predReady)
		else $error("ready during load");
	a_load_full: assert property (coefValid && coefReady && nLoad_reg != 6'h3f |=> coefReady)
		else $error("load ended early");
	a_load_end: assert property ($fell(coefReady) |-> nLoad_reg == 6'h00)
		else $error("load ended off count");
	a_load_wait: assert property ($fell(coefReady) |-> ##128 !coefReady)
		else $error("load reopened early");
endmodule // bpr_recon_sva

// >>> sim/bpr_pred_src.sv
`timescale 1ns/1ps
// ****
// prediction source
// ****
module bpr_pred_src (
	// clock
	input wire sys_clk,
	// handshake
	output logic predValid,
	input wire predReady,
	output logic [7:0] predData
);
	logic [7:0] q[$];
	logic slow = 0;
	logic go;
	logic pace = 0;
	initial begin
		predValid = 0;
		predData = 8'h5a;
	end
	// offer queued pixels, hold each until taken
	always @(posedge sys_clk) begin
		go = !predValid || predReady;
		pace = ~pace;
		#1;
		if (go && q.size() && !(slow && pace)) begin
			predValid = 1;
			predData = q.pop_front();
		end else if (go) begin
			predValid = 0;
			predData = ~predData; // no stale data left standing
		end
	end
endmodule // bpr_pred_src

// >>> sim/bpr_recon_test.sv
`timescale 1ns/1ps
// ****
// reconstruction bench
// ****
module bpr_recon_test;
	logic sys_clk = 0;
	logic rstn = 0;
	logic coefValid = 0;
	logic [11:0] coefData = 12'h000;
	logic blkIntra = 0;
	logic pixReady = 0;
	wire coefReady, predValid, predReady, pixValid;
	wire [7:0] predData, pixData;
	localparam real PI = 3.14159265358979;
	localparam real LCG_DIV = 2147483647.0; // scale divisor of the random source
	int seed = 24;
	int lcgState = 1; // start state of the random source, free choice
	int fails = 0;
	int totalChecks = 0;
	logic [7:0] exp[$];
	int tol[$];
	real errSq = 0.0;
	int errCnt = 0;
	// clock
	always #10 sys_clk = ~sys_clk;
	bpr_recon DUT (.*);
	bpr_pred_src P (.*);
	// score taken pixels within tolerance, then stall at random
	always @(posedge sys_clk) begin
		int d;
		if (pixValid && pixReady) begin
			totalChecks++;
			d = exp.size() ? int'(pixData) - int'(exp[0]) : 0;
			if (exp.size() == 0 || $isunknown(pixData) || d > tol[0] || -d > tol[0]) begin
				fails++;
				$display("CHECK FAILED %0t pixel %h", $time, pixData);
			end
			if (exp.size() && tol[0] > 0) begin
				errSq += d * d;
				errCnt++;
			end
			if (exp.size()) begin
				void'(exp.pop_front());
				void'(tol.pop_front());
			end
		end
		#1 pixReady = ($random(seed) & 3) != 0;
	end
	// linear congruential source, range -lo..hi
	function automatic int lcgDraw(input int lo, input int hi);
		int i;
		real x;
		lcgState = lcgState * 1103515245 + 12345;
		i = lcgState & 32'h7ffffffe;
		x = i / LCG_DIV;
		x = x * (lo + hi + 1);
		return $rtoi(x) - lo;
	endfunction
	// weighted cosine of the orthonormal 8-point transform
	function automatic real cw(input int s, input int f);
		real k;
		k = f ? 1.0 : 0.70710678118654752;
		return k * $cos(PI * (2 * s + 1) * f / 16.0);
	endfunction
	function automatic int clamp(input int v, input int lo, input int hi);
		return v < lo ? lo : v > hi ? hi : v;
	endfunction
	task automatic giveVerdict;
		$display("checks %0d fails %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// offer 64 coefficients, one edge apart from the previous block
	task automatic sendCoefs(input logic intra, input int c[64]);
		int i;
		int e;
		logic ok;
		@(posedge sys_clk);
		#1;
		blkIntra = intra;
		coefValid = 1;
		i = 0;
		for (e = 0; i < 64; e++) begin
			if (e > 999) begin
				fails++;
				giveVerdict;
			end
			coefData = 12'(c[i]);
			ok = coefReady;
			@(posedge sys_clk);
			#1;
			if (ok)
				i++;
		end
		coefValid = 0;
	endtask
	// note expectations, queue predictions for inter blocks, send a dc-only block
	task automatic sendBlock(input logic intra, input int r);
		int i;
		int e;
		int p;
		int c[64];
		for (i = 0; i < 64; i++) begin
			p = intra ? 0 : $random(seed) & 255;
			if (!intra)
				P.q.push_back(p[7:0]);
			e = r + p;
			exp.push_back(e < 0 ? 8'h00 : e > 255 ? 8'hff : e[7:0]);
			tol.push_back(0);
			c[i] = i ? 0 : 8 * r;
		end
		sendCoefs(intra, c);
	endtask
	// forward transform, round, clip; reference inverse gives expectations
	task automatic conformBlock(input int pix[64], input int sgn);
		int u;
		int v;
		int x;
		int y;
		int p;
		int refVal;
		real s;
		int c[64];
		for (v = 0; v < 8; v++)
			for (u = 0; u < 8; u++) begin
				s = 0.0;
				for (y = 0; y < 8; y++)
					for (x = 0; x < 8; x++)
						s += sgn * pix[y * 8 + x] * cw(x, u) * cw(y, v);
				c[v * 8 + u] = clamp(int'(s / 4.0), -2048, 2047);
			end
		for (y = 0; y < 8; y++)
			for (x = 0; x < 8; x++) begin
				s = 0.0;
				for (v = 0; v < 8; v++)
					for (u = 0; u < 8; u++)
						s += c[v * 8 + u] * cw(x, u) * cw(y, v);
				refVal = clamp(int'(s / 4.0), -256, 255);
				p = $random(seed) & 255;
				P.q.push_back(p[7:0]);
				exp.push_back(8'(clamp(refVal + p, 0, 255)));
				tol.push_back(1);
			end
		sendCoefs(1'b0, c);
	endtask
	// main sequence
	initial begin
		int n;
		int g;
		int rs[3] = '{0, -256, 255};
		int lims[3] = '{256, 5, 300};
		int blk[64];
		repeat (2) @(posedge sys_clk);
		#1 rstn = 1;
		for (n = 0; n < 12; n++) begin
			P.slow = n > 7;
			sendBlock(!n[0], n < 3 ? rs[n] : $random(seed) % 256);
			$display("block %0d sent", n);
		end
		// two blocks per range keep the run short
		for (n = 0; n < 6; n++) begin
			for (g = 0; g < 64; g++)
				blk[g] = lcgDraw(lims[n / 2], lims[n / 2] - (n < 2));
			conformBlock(blk, 1);
			conformBlock(blk, -1);
			$display("conformance block %0d sent", n);
		end
		for (g = 0; g < 3000 && exp.size(); g++)
			@(posedge sys_clk);
		if (exp.size()) begin
			fails++;
			$display("CHECK FAILED %0t pixels missing", $time);
		end
		totalChecks++;
		if (errCnt == 0 || errSq / errCnt > 0.06) begin
			fails++;
			$display("CHECK FAILED %0t mean square error too high", $time);
		end
		giveVerdict;
	end
endmodule // bpr_recon_test
bind bpr_recon bpr_recon_sva SVA (.*);
